// File: src/spfm_top.sv
// Four-mode serial port with an APB register slave and a transmit FIFO.
// Assumes timer overflow pulses come from logic on pclk and rxd_in is an
// asynchronous pin with an external pull-up.
// Operation
// - The port offers mode 0 (synchronous) and modes 1 to 3 (async, start and stop bit).
// - Modes 1 and 3 are clocked by timer overflows and carry 8 or 9 data bits.
// - Mode 2 carries 9 data bits at the system clock divided by 32 or 64.
// - Mode 0 is a half-duplex master: data on the receive pin, shift clock on transmit pin.
// - Mode 0 moves exactly eight bits per transfer, LSB first, in both directions.
// - A data write starts a mode 0 send and the done flag sets after the eighth bit.
// - A mode 0 receive starts only with receive enabled and the receive flag clear.
// - The receive flag sets one cycle after the eighth bit and blocks until cleared.
// - An enabled interrupt is raised while either done flag is set.
// - The mode 0 shift clock is the system clock divided by twelve.
// - In mode 0 the data pin is driven open-drain.
// - In modes 2 and 3 the ninth bit is one for an address and zero for data.
// - With the filter bit set, a frame whose ninth bit is zero is not reported.
// - The receive timer select picks timer one (0) or timer two (1) overflows.
// - The transmit timer select picks timer one (0) or timer two (1) overflows.
// - While either select bit is set the timer two overflow flag is not set.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spfm_regs.svh"

// Plain FIFO; the writer stalls on in_ready and the reader on out_valid.
module spfm_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic pce, // Clock enable.
   input wire logic in_valid, // Word offered.
   output logic in_ready, // Room for a word.
   input wire logic [W-1:0] in_data, // Word in.
   output logic out_valid, // Word available.
   input wire logic out_ready, // Word taken.
   output logic [W-1:0] out_data // Oldest word.
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // Pointer and count update; full and empty come from the count alone.
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   assign in_ready = (cnt_r != D[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];

   // Storage has no reset; only words below the count are ever read.
   always_ff @(posedge pclk) begin
      if (pce && push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (pce) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule // spfm_fifo

module spfm_top
   import spfm_pkg::*;
(
   input wire logic pclk, // System clock, 40 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic pce, // Clock enable, freezes all state when low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic timer_one_ovf, // Timer one overflow pulse.
   input wire logic timer_two_ovf, // Timer two overflow pulse.
   input wire logic rxd_in, // Receive pin level.
   output logic rxd_out, // Receive pin drive value.
   output logic rxd_oe, // Receive pin output enable.
   output logic txd_out, // Transmit pin.
   output logic serial_irq // Serial port interrupt.
);
   // Register state.
   logic [1:0] mode_r, mode_nxt;
   logic ren_r, ren_nxt, filt_r, filt_nxt, tx9_r, tx9_nxt, rx9_r, rx9_nxt;
   logic tdone_r, tdone_nxt, rdone_r, rdone_nxt, ien_r, ien_nxt, div32_r, div32_nxt;
   logic [7:0] t2c_r, t2c_nxt, rbuf_r, rbuf_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt, pslverr_nxt, irq_nxt;
   // Bus decode.
   logic acc, commit, hit, wr_ctrl, wr_t2c, wr_data;
   // Events into the flags.
   logic tdone_evt, rdone_evt, rx_load;
   logic [7:0] rx_byte;
   logic rx_ninth;
   // FIFO ports.
   logic f_ready, f_valid, f_pop;
   logic [`SPFM_FIFO_W-1:0] f_data;
   // Pin synchroniser and prescaler.
   logic rxd_m_r, rxd_s_r, rxd_d_r;
   logic [1:0] pre_r, pre_nxt;
   logic m2_tick, tx_tick, rx_tick;
   // Transmit and mode 0 engine.
   spfm_tx_type tx_st_r, tx_st_nxt;
   logic [10:0] tsh_r, tsh_nxt;
   logic [3:0] tbit_r, tbit_nxt, tph_r, tph_nxt;
   logic [4:0] ttk_r, ttk_nxt;
   logic m0rx_r, m0rx_nxt, txd_nxt, oe_nxt;
   // Asynchronous receiver.
   spfm_rx_type rx_st_r, rx_st_nxt;
   logic [9:0] rsh_r, rsh_nxt;
   logic [3:0] rbit_r, rbit_nxt, rph_r, rph_nxt;

   // Clock source for modes 1 and 3, chosen per direction.
   function automatic logic baud_src(input logic sel, input logic t1, input logic t2);
      baud_src = sel ? t2 : t1;
   endfunction

   // Frame length in bits: 10 in mode 1, 11 with a ninth bit.
   function automatic logic [3:0] frame_len(input logic [1:0] m);
      frame_len = (m == SPFM_M1) ? 4'hA : 4'hB;
   endfunction

   assign acc = psel && penable;
   assign commit = acc && pready;
   assign hit = (paddr == `SPFM_CTRL_OFF) || (paddr == `SPFM_DATA_OFF) ||
                (paddr == `SPFM_T2C_OFF);
   assign wr_ctrl = commit && pwrite && (paddr == `SPFM_CTRL_OFF);
   assign wr_t2c = commit && pwrite && (paddr == `SPFM_T2C_OFF);
   assign wr_data = commit && pwrite && (paddr == `SPFM_DATA_OFF);

   // Writes queue frames so software can stay ahead of a slow baud clock.
   spfm_fifo #(.W(`SPFM_FIFO_W), .D(`SPFM_FIFO_D)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .pce(pce),
      .in_valid(wr_data),
      .in_ready(f_ready),
      .in_data({tx9_r, pwdata[7:0]}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // APB answer: one wait cycle, longer while a data write meets a full FIFO.
   always_comb begin
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt = prdata;
      if (acc && !pready) begin
         pready_nxt = !(pwrite && paddr == `SPFM_DATA_OFF && !f_ready);
         pslverr_nxt = !hit;
         case (paddr)
            `SPFM_CTRL_OFF: prdata_nxt = {22'h0, div32_r, ien_r, rdone_r, tdone_r,
                                          rx9_r, tx9_r, filt_r, ren_r, mode_r};
            `SPFM_DATA_OFF: prdata_nxt = {24'h0, rbuf_r};
            `SPFM_T2C_OFF: prdata_nxt = {24'h0, t2c_r};
            default: prdata_nxt = 32'h0;
         endcase
      end
   end

   // Register next values; a hardware set beats a software clear in the same cycle.
   always_comb begin
      mode_nxt = mode_r;
      ren_nxt = ren_r;
      filt_nxt = filt_r;
      tx9_nxt = tx9_r;
      ien_nxt = ien_r;
      div32_nxt = div32_r;
      t2c_nxt = t2c_r;
      tdone_nxt = tdone_r;
      rdone_nxt = rdone_r;
      if (wr_ctrl) begin
         mode_nxt = pwdata[`SPFM_C_MODE +: 2];
         ren_nxt = pwdata[`SPFM_C_REN];
         filt_nxt = pwdata[`SPFM_C_FILT];
         tx9_nxt = pwdata[`SPFM_C_TX9];
         ien_nxt = pwdata[`SPFM_C_IEN];
         div32_nxt = pwdata[`SPFM_C_DIV32];
         tdone_nxt = tdone_r && !pwdata[`SPFM_C_TDONE];
         rdone_nxt = rdone_r && !pwdata[`SPFM_C_RDONE];
      end
      if (wr_t2c) begin
         t2c_nxt = {t2c_r[7] && !pwdata[7], pwdata[6:0]};
      end
      if (timer_two_ovf && !t2c_r[`SPFM_T_RSEL] && !t2c_r[`SPFM_T_TSEL]) begin
         t2c_nxt[`SPFM_T_OVF] = 1'b1;
      end
      tdone_nxt = tdone_nxt || tdone_evt;
      rdone_nxt = rdone_nxt || rdone_evt;
      rbuf_nxt = rdone_evt ? rx_byte : rbuf_r;
      rx9_nxt = (rdone_evt && mode_r != SPFM_M0) ? rx_ninth : rx9_r;
      irq_nxt = ien_nxt && (tdone_nxt || rdone_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         {div32_r, ien_r, rdone_r, tdone_r, rx9_r, tx9_r, filt_r, ren_r, mode_r} <=
            `SPFM_CTRL_RST;
         t2c_r <= `SPFM_T2C_RST;
         rbuf_r <= 8'h00;
         serial_irq <= 1'b0;
      end else if (pce) begin
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         mode_r <= mode_nxt;
         ren_r <= ren_nxt;
         filt_r <= filt_nxt;
         tx9_r <= tx9_nxt;
         rx9_r <= rx9_nxt;
         tdone_r <= tdone_nxt;
         rdone_r <= rdone_nxt;
         ien_r <= ien_nxt;
         div32_r <= div32_nxt;
         t2c_r <= t2c_nxt;
         rbuf_r <= rbuf_nxt;
         serial_irq <= irq_nxt;
      end
   end

   // Sixteen ticks make one bit; mode 2 ticks every 2 or 4 clocks (32 or 64 per bit).
   always_comb begin
      pre_nxt = pre_r + 2'h1;
      m2_tick = (pre_r & (div32_r ? `SPFM_M2_FAST : `SPFM_M2_SLOW)) ==
                (div32_r ? `SPFM_M2_FAST : `SPFM_M2_SLOW);
      tx_tick = (mode_r == SPFM_M2) ? m2_tick :
                baud_src(t2c_r[`SPFM_T_TSEL], timer_one_ovf, timer_two_ovf);
      rx_tick = (mode_r == SPFM_M2) ? m2_tick :
                baud_src(t2c_r[`SPFM_T_RSEL], timer_one_ovf, timer_two_ovf);
   end

   // The pin passes two flops; the third stage only feeds the edge detector.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_m_r <= 1'b1;
         rxd_s_r <= 1'b1;
         rxd_d_r <= 1'b1;
         pre_r <= 2'h0;
      end else if (pce) begin
         rxd_m_r <= rxd_in;
         rxd_s_r <= rxd_m_r;
         rxd_d_r <= rxd_s_r;
         pre_r <= pre_nxt;
      end
   end

   // Transmit engine; mode 0 receive shares it because the link is half duplex.
   always_comb begin
      tx_st_nxt = tx_st_r;
      tsh_nxt = tsh_r;
      tbit_nxt = tbit_r;
      tph_nxt = tph_r;
      ttk_nxt = ttk_r;
      m0rx_nxt = m0rx_r;
      f_pop = 1'b0;
      tdone_evt = 1'b0;
      txd_nxt = 1'b1;
      oe_nxt = 1'b0;
      case (tx_st_r)
         TX_IDLE: begin
            tph_nxt = 4'h0;
            tbit_nxt = 4'h0;
            ttk_nxt = 5'h00;
            if (f_valid) begin
               f_pop = 1'b1;
               m0rx_nxt = 1'b0;
               if (mode_r == SPFM_M0) begin
                  tsh_nxt = {3'h7, f_data[7:0]};
                  tx_st_nxt = TX_SYNC;
               end else begin
                  tsh_nxt = {1'b1, (mode_r == SPFM_M1) ? 1'b1 : f_data[8],
                             f_data[7:0], 1'b0};
                  tx_st_nxt = TX_ASYNC;
               end
            end else if (mode_r == SPFM_M0 && ren_r && !rdone_r) begin
               m0rx_nxt = 1'b1;
               tx_st_nxt = TX_SYNC;
            end
         end
         TX_SYNC: begin
            // Clock low for six cycles then high for six: twelve per bit.
            txd_nxt = (tph_r >= 4'h6);
            oe_nxt = !m0rx_r && !tsh_r[0];
            tph_nxt = tph_r + 4'h1;
            if (tph_r == `SPFM_M0_DIV - 4'h1) begin
               tph_nxt = 4'h0;
               tbit_nxt = tbit_r + 4'h1;
               // Received bits enter at bit 7, so the byte sits in [7:0] after the eighth shift.
               tsh_nxt = {3'h7, rxd_s_r, tsh_r[7:1]};
               if (tbit_r == 4'h7) begin
                  tx_st_nxt = m0rx_r ? TX_SFIN : TX_IDLE;
                  tdone_evt = !m0rx_r;
               end
            end
         end
         TX_SFIN: begin
            tx_st_nxt = TX_IDLE;
         end
         TX_ASYNC: begin
            txd_nxt = tsh_r[0];
            if (tx_tick) begin
               ttk_nxt = ttk_r + 5'h01;
               if (ttk_r == `SPFM_OVS - 5'h01) begin
                  ttk_nxt = 5'h00;
                  tsh_nxt = {1'b1, tsh_r[10:1]};
                  tbit_nxt = tbit_r + 4'h1;
                  if (tbit_r == frame_len(mode_r) - 4'h1) begin
                     tx_st_nxt = TX_IDLE;
                     tdone_evt = 1'b1;
                  end
               end
            end
            txd_nxt = (tx_st_nxt == TX_ASYNC) ? tsh_nxt[0] : 1'b1;
         end
         default: tx_st_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r <= TX_IDLE;
         tsh_r <= 11'h7FF;
         tbit_r <= 4'h0;
         tph_r <= 4'h0;
         ttk_r <= 5'h00;
         m0rx_r <= 1'b0;
         txd_out <= 1'b1;
         rxd_oe <= 1'b0;
         rxd_out <= 1'b0;
      end else if (pce) begin
         tx_st_r <= tx_st_nxt;
         tsh_r <= tsh_nxt;
         tbit_r <= tbit_nxt;
         tph_r <= tph_nxt;
         ttk_r <= ttk_nxt;
         m0rx_r <= m0rx_nxt;
         txd_out <= txd_nxt;
         rxd_oe <= oe_nxt;
         rxd_out <= 1'b0;
      end
   end

   // Asynchronous receiver: mid-bit sampling on the sixteen-tick grid.
   always_comb begin
      rx_st_nxt = rx_st_r;
      rsh_nxt = rsh_r;
      rbit_nxt = rbit_r;
      rph_nxt = rph_r;
      rx_load = 1'b0;
      case (rx_st_r)
         RX_IDLE: begin
            rph_nxt = 4'h0;
            rbit_nxt = 4'h0;
            if (mode_r != SPFM_M0 && ren_r && rxd_d_r && !rxd_s_r) begin
               rx_st_nxt = RX_START;
            end
         end
         RX_START: begin
            if (rx_tick) begin
               rph_nxt = rph_r + 4'h1;
               if (rph_r == 4'h7) begin
                  rph_nxt = 4'h0;
                  rx_st_nxt = rxd_s_r ? RX_IDLE : RX_BITS;
               end
            end
         end
         RX_BITS: begin
            if (rx_tick) begin
               rph_nxt = rph_r + 4'h1;
               if (rph_r == 4'hF) begin
                  rsh_nxt = {rxd_s_r, rsh_r[9:1]};
                  rbit_nxt = rbit_r + 4'h1;
                  if (rbit_r == frame_len(mode_r) - 4'h2) begin
                     rx_st_nxt = RX_IDLE;
                     rx_load = 1'b1;
                  end
               end
            end
         end
         default: rx_st_nxt = RX_IDLE;
      endcase
      // Mode 1 frames are one bit shorter, so the word sits one place higher.
      rx_byte = (mode_r == SPFM_M1) ? rsh_nxt[8:1] : rsh_nxt[7:0];
      rx_ninth = (mode_r == SPFM_M1) ? rsh_nxt[9] : rsh_nxt[8];
      if (mode_r == SPFM_M0) begin
         rx_byte = tsh_r[7:0];
      end
      rdone_evt = (tx_st_r == TX_SFIN) ||
                  (rx_load && !rdone_r && (!filt_r || rx_ninth));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_r <= RX_IDLE;
         rsh_r <= 10'h000;
         rbit_r <= 4'h0;
         rph_r <= 4'h0;
      end else if (pce) begin
         rx_st_r <= rx_st_nxt;
         rsh_r <= rsh_nxt;
         rbit_r <= rbit_nxt;
         rph_r <= rph_nxt;
      end
   end
endmodule // spfm_top
`default_nettype wire

// File: pkg/spfm_regs.svh
// Register map, field positions, reset values and timing counts of the serial port.
// Included by the package and by the design; holds definitions only.
`ifndef SPFM_REGS_SVH
`define SPFM_REGS_SVH
`define SPFM_ADDR_W 12
`define SPFM_CTRL_OFF 12'h000
`define SPFM_DATA_OFF 12'h004
`define SPFM_T2C_OFF 12'h008
`define SPFM_CTRL_RST 10'h000
`define SPFM_T2C_RST 8'h00
`define SPFM_C_MODE 0
`define SPFM_C_REN 2
`define SPFM_C_FILT 3
`define SPFM_C_TX9 4
`define SPFM_C_RX9 5
`define SPFM_C_TDONE 6
`define SPFM_C_RDONE 7
`define SPFM_C_IEN 8
`define SPFM_C_DIV32 9
`define SPFM_T_OVF 7
`define SPFM_T_RSEL 5
`define SPFM_T_TSEL 4
`define SPFM_M0_DIV 4'hC
`define SPFM_OVS 5'h10
`define SPFM_M2_FAST 2'h1
`define SPFM_M2_SLOW 2'h3
`define SPFM_FIFO_W 9
`define SPFM_FIFO_D 4
`endif

// File: pkg/spfm_pkg.sv
// Types used by the serial port design: modes and engine states.
// Assumes the register header is on the include path.
package spfm_pkg;
   `include "spfm_regs.svh"
   typedef enum logic [1:0] {SPFM_M0, SPFM_M1, SPFM_M2, SPFM_M3} spfm_mode_type;
   typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SFIN, TX_ASYNC} spfm_tx_type;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} spfm_rx_type;
endpackage

// File: dv/spfm_asserts.sv
// Checker for spfm_top: APB timing, open-drain pin and mode 0 shift clock.
// Assumes pce drops only while the bus is idle; bound to every spfm_top.
`timescale 1ns/1ps
`default_nettype none
module spfm_asserts (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB address.
   input wire logic [31:0] prdata, // APB read data.
   input wire logic pready, // APB ready.
   input wire logic pslverr, // APB error.
   input wire logic rxd_out, // Receive pin drive value.
   input wire logic rxd_oe, // Receive pin enable.
   input wire logic txd_out, // Transmit pin.
   input wire logic serial_irq // Interrupt.
);
   // Only a committed write may clear a done flag or the enable.
   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Async bits are at least 16 cycles long, so both shapes hold for them too.
   sequence s_low6; !txd_out [*6]; endsequence
   sequence s_high6; txd_out [*6]; endsequence
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   chk_setup_wait: assert property (psel && !penable |-> !pready)
      else $error("pready in setup cycle");
   chk_access_wait: assert property ($rose(penable) && psel && !(pwrite && paddr == 12'h004)
      |-> !pready ##1 pready) else $error("register access not one wait state");
   chk_err_map: assert property (psel && penable && pready
      |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008})) else $error("pslverr wrong");
   chk_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   chk_drain_low: assert property (rxd_oe |-> !rxd_out)
      else $error("receive pin driven high");
   chk_shift_low: assert property ($fell(txd_out) |-> s_low6)
      else $error("shift clock low half short");
   chk_shift_high: assert property ($rose(txd_out) |-> s_high6)
      else $error("shift clock high half short");
   chk_irq_clear: assert property ($fell(serial_irq) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("interrupt fell without a write");
endmodule // spfm_asserts
bind spfm_top spfm_asserts spfm_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
   .serial_irq(serial_irq));
`default_nettype wire

// File: dv/spfm_peer.sv
// Remote serial peer: mode 0 slave and async frame sender and receiver.
// Assumes the bench resolves the open-drain receive pin from drv and rxd_oe.
`timescale 1ns/1ps
`default_nettype none
module spfm_peer (
   input wire logic pclk, // Clock.
   input wire logic txd, // Device transmit pin.
   input wire logic pin, // Resolved receive pin.
   output logic drv // Peer drive, 1 means released to the pull-up.
);
   logic arm = 1'b0;
   logic txd_q = 1'b1;
   logic [7:0] m0_out = 8'h00;
   logic [7:0] m0_in = 8'h00;
   int k = 0;
   int rises = 0;
   initial drv = 1'b1;
   // Mode 0: data taken at the rising shift clock, next bit put out at the falling one.
   always @(posedge pclk) begin
      txd_q <= txd;
      if (txd && !txd_q) begin
         rises <= rises + 1;
         if (!arm) m0_in <= {pin, m0_in[7:1]};
      end
      if (!txd && txd_q && arm) begin
         drv <= m0_out[k[2:0]];
         k <= k + 1;
      end
   end
   task automatic m0_load(input logic [7:0] v);
      m0_out = v;
      k = 0;
      arm = 1'b1;
   endtask
   // Released after the transfer, so the pin goes back to the pull-up level.
   task automatic m0_release();
      arm = 1'b0;
      drv <= 1'b1;
   endtask
   // Samples mid-bit; bit nb of the result is the stop bit.
   task automatic get_frame(input int per, input int nb, output logic [9:0] v);
      v = '0;
      do @(posedge pclk); while (txd);
      repeat (per / 2) @(posedge pclk);
      for (int i = 0; i <= nb; i++) begin
         repeat (per) @(posedge pclk);
         v[i] = txd;
      end
   endtask
   // Start bit, data LSB first, stop bit.
   task automatic put_frame(input int per, input logic [8:0] d, input int nb);
      drv <= 1'b0;
      repeat (per) @(posedge pclk);
      for (int i = 0; i < nb; i++) begin
         drv <= d[i];
         repeat (per) @(posedge pclk);
      end
      drv <= 1'b1;
      repeat (per) @(posedge pclk);
   endtask
endmodule // spfm_peer
`default_nettype wire

// File: dv/spfm_top_tb.sv
// Self-checking bench for spfm_top over APB with a serial peer model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module spfm_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic timer_one_ovf = 1'b0;
   logic timer_two_ovf = 1'b0;
   logic ten = 1'b0;
   logic pce = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, rxd_out, rxd_oe, txd_out, serial_irq, drv, rxd_in;
   logic [9:0] fr;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;
   int t0;
   int per[4] = '{80, 48, 64, 32};
   int nbt[4] = '{8, 9, 9, 9};
   logic [31:0] ctl[4] = '{32'h001, 32'h013, 32'h002, 32'h212};
   logic [31:0] t2c[4] = '{32'h00, 32'h10, 32'h10, 32'h10};
   logic [7:0] dat[4] = '{8'hC3, 8'h5A, 8'h81, 8'h0F};
   logic [9:0] fx[4] = '{10'h1C3, 10'h35A, 10'h281, 10'h30F};
   `define CHK(what, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
      $display("BAD %s exp %h got %h", what, e, g); end end
   // Open drain: the port pulls low, otherwise the peer or the pull-up decides.
   assign rxd_in = rxd_oe ? 1'b0 : drv;
   initial forever #12.5 pclk = ~pclk;
   // Distinct overflow rates make a wrong timer choice show as garbled bits.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      timer_one_ovf <= (cyc % 5 == 0);
      timer_two_ovf <= ten && (cyc % 3 == 0);
      if (cyc == 60000) begin
         error_cnt++;
         print_verdict();
      end
   end
   spfm_top spfm_top_i (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_one_ovf(timer_one_ovf),
      .timer_two_ovf(timer_two_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
      .txd_out(txd_out), .serial_irq(serial_irq));
   spfm_peer spfm_peer_i (.pclk(pclk), .txd(txd_out), .pin(rxd_in), .drv(drv));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string what);
      apb(1'b0, a, 32'h00000000);
      `CHK(what, e, rd)
   endtask
   task automatic wait_irq(input logic v);
      for (int i = 0; i < 4000 && serial_irq !== v; i++) @(posedge pclk);
      `CHK("irq", v, serial_irq)
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h000, 32'h000, "ctrl reset");
      rdc(12'h008, 32'h000, "t2c reset");
      rdc(12'h00C, 32'h000, "unmapped read");
      `CHK("slverr", 1'b1, err)
      // Timer two flag sets, then stays clear while a select bit is one.
      ten = 1'b1;
      repeat (8) @(posedge pclk);
      rdc(12'h008, 32'h80, "t2 flag");
      apb(1'b1, 12'h008, 32'h10);
      apb(1'b1, 12'h008, 32'h90);
      repeat (8) @(posedge pclk);
      rdc(12'h008, 32'h10, "t2 flag held");
      // Mode 0 send.
      apb(1'b1, 12'h000, 32'h100);
      apb(1'b1, 12'h004, 32'hA5);
      // Freeze mid-transfer: no rising shift clock edge may reach the peer while pce is low.
      repeat (20) @(posedge pclk);
      pce <= 1'b0;
      repeat (2) @(posedge pclk);
      t0 = spfm_peer_i.rises;
      repeat (30) @(posedge pclk);
      `CHK("frozen clock", t0, spfm_peer_i.rises)
      pce <= 1'b1;
      wait_irq(1'b1);
      `CHK("m0 tx byte", 8'hA5, spfm_peer_i.m0_in)
      rdc(12'h000, 32'h140, "tdone");
      apb(1'b1, 12'h000, 32'h140);
      wait_irq(1'b0);
      // Mode 0 receive, then no shift clock while the flag stays set.
      spfm_peer_i.m0_load(8'h3C);
      apb(1'b1, 12'h000, 32'h104);
      wait_irq(1'b1);
      spfm_peer_i.m0_release();
      rdc(12'h004, 32'h3C, "m0 rx byte");
      rdc(12'h000, 32'h184, "rdone");
      t0 = spfm_peer_i.rises;
      repeat (100) @(posedge pclk);
      `CHK("rx halted", t0, spfm_peer_i.rises)
      apb(1'b1, 12'h000, 32'h180);
      wait_irq(1'b0);
      // Async sends, one row per mode and clock source.
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h008, t2c[i]);
         apb(1'b1, 12'h000, ctl[i]);
         apb(1'b1, 12'h004, {24'h000000, dat[i]});
         spfm_peer_i.get_frame(per[i], nbt[i], fr);
         `CHK("async frame", fx[i], fr)
         // Let the stop bit end so new settings never meet a busy sender.
         repeat (per[i]) @(posedge pclk);
      end
      // Mode 3 receive with the filter on; timer two clocks the receive side.
      apb(1'b1, 12'h008, 32'h20);
      apb(1'b1, 12'h000, 32'h14F);
      spfm_peer_i.put_frame(48, 9'h033, 9);
      repeat (100) @(posedge pclk);
      rdc(12'h000, 32'h10F, "filtered");
      spfm_peer_i.put_frame(48, 9'h177, 9);
      wait_irq(1'b1);
      rdc(12'h004, 32'h77, "async rx byte");
      rdc(12'h000, 32'h1AF, "address rx");
      // Back-to-back data writes until the buffer refuses, then drain.
      apb(1'b1, 12'h000, 32'h212);
      for (int i = 0; i < 5; i++) apb(1'b1, 12'h004, i);
      t0 = cyc;
      apb(1'b1, 12'h004, 32'h55);
      `CHK("fifo stall", 1'b1, (cyc - t0) > 20)
      repeat (2500) @(posedge pclk);
      `CHK("drained idle", 1'b1, txd_out)
      print_verdict();
   end
endmodule // spfm_top_tb
`default_nettype wire
